// [tb/cx_exec_core_tb.sv]
/*
 Self-checking bench of the execution core over APB.
 Assumes the far-side model and zero-wait APB answers.
*/
`default_nettype none
module cx_exec_core_tb
  import cx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] ins, a, b, res;
    logic        ci, co;
  } cx_row_t;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  cx_mem_t     mem_o, m_last;
  cx_cache_t   cache_o, c_last;
  int          m_cnt, dc_cnt, ic_cnt, bad_cnt;
  int          num_errors = 0;
  int          compares   = 0;
  int          cyc        = 0;
  cx_row_t rows[16] = '{
    '{32'h24600005, 32'h3, 32'h0, 32'h2, 1'b0, 1'b1},
    '{32'h24600003, 32'h5, 32'h0, 32'hfffffffe, 1'b1, 1'b0},
    '{32'h2c600005, 32'h3, 32'h0, 32'h1, 1'b0, 1'b1},
    '{32'h2c600005, 32'h3, 32'h0, 32'h2, 1'b1, 1'b1},
    '{32'h34600003, 32'h5, 32'h0, 32'hfffffffe, 1'b1, 1'b1},
    '{32'h3c600005, 32'h3, 32'h0, 32'h1, 1'b0, 1'b0},
    '{32'h24608000, 32'h0, 32'h0, 32'hffff8000, 1'b0, 1'b1},
    '{32'h88000000, 32'hf0f01234, 32'h0ff0ffff, 32'hff00edcb, 1'b1, 1'b1},
    '{32'ha8008001, 32'h12340000, 32'h0, 32'h12348001, 1'b0, 1'b0},
    '{32'h90000001, 32'h80000003, 32'h0, 32'hc0000001, 1'b0, 1'b1},
    '{32'h90000021, 32'h2, 32'h0, 32'h80000001, 1'b1, 1'b0},
    '{32'h90000041, 32'h80000001, 32'h0, 32'h40000000, 1'b0, 1'b1},
    '{32'h90000060, 32'h12345680, 32'h0, 32'hffffff80, 1'b1, 1'b1},
    '{32'h90000060, 32'habcdef7f, 32'h0, 32'h0000007f, 1'b0, 1'b0},
    '{32'h90000061, 32'h12348001, 32'h0, 32'hffff8001, 1'b0, 1'b0},
    '{32'h90000061, 32'hffff7fff, 32'h0, 32'h00007fff, 1'b1, 1'b1}};
  logic [31:0] st_ins[6] = '{32'hd0000000, 32'hd4000000, 32'hd8000000,
                             32'hf000fffe, 32'hf400fffe, 32'hf800fffe};
  logic [31:0] st_adr[6] = '{32'h1007, 32'h1006, 32'h1004,
                             32'h0ffe, 32'h0ffe, 32'h0ffc};
  logic [31:0] r_ins[3] = '{32'hb640fff0, 32'hb620fff0, 32'hb600fff0};
  logic [31:0] r_in[3]  = '{32'h2, 32'h0, 32'h0};
  logic [31:0] r_out[3] = '{32'h0, 32'h4, 32'h0};
  cx_row_t c_rows[4] = '{
    '{32'h90000064, 32'h1232, 32'hdeadbeef, 32'h00, 1'b1, 1'b0},
    '{32'h90000064, 32'h1232, 32'hdeadbeef, 32'h08, 1'b0, 1'b0},
    '{32'h90000068, 32'h4441, 32'h12345678, 32'h00, 1'b0, 1'b1},
    '{32'h90000068, 32'h4441, 32'h12345678, 32'h10, 1'b0, 1'b0}};

  cx_exec_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_o(mem_o),
    .cache_o(cache_o));
  cx_far_model i_far (.pclk(pclk), .mem_i(mem_o), .cache_i(cache_o),
    .mem_last(m_last), .cache_last(c_last), .mem_cnt(m_cnt),
    .dc_cnt(dc_cnt), .ic_cnt(ic_cnt), .bad_cnt(bad_cnt));

  always #20 pclk = ~pclk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= adr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, adr, v, d, e);
    check("write error", {31'h0, e}, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp,
                     input string nm);
    logic [31:0] d;
    logic        e;
    apb(1'b0, adr, 32'h0, d, e);
    check(nm, d, exp);
  endtask

  task automatic ex(input logic [31:0] ins, a, b, ms);
    wr(A_SRC_A, a);
    wr(A_SRC_B, b);
    wr(A_MSTATE, ms);
    wr(A_INSTR, ins);
  endtask

  initial begin
    logic [31:0] d, msk;
    logic        e;
    int          m0, d0, i0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_PC, 32'h0, "pc after reset");
    rdc(A_MSTATE, 32'h0, "flags after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      ex(rows[i].ins, rows[i].a, rows[i].b, {31'h0, rows[i].ci});
      rdc(A_RESULT, rows[i].res, "result");
      rdc(A_MSTATE, {31'h0, rows[i].co}, "carry");
    end
    ex(32'h24600005, 32'h3, 32'h0, 32'h0);
    rdc(A_STATUS, 32'h300, "dest index");
    $display("test table done");
    wr(A_DATA, 32'h11223344);
    foreach (st_ins[i]) begin
      m0 = m_cnt;
      msk = (i % 3 == 0) ? 32'hff : (i % 3 == 1) ? 32'hffff : 32'hffffffff;
      ex(st_ins[i], 32'h1000, 32'h7, 32'h0);
      @(posedge pclk);
      check("stores", 32'(m_cnt - m0), 32'h1);
      check("store addr", m_last.addr, st_adr[i]);
      check("store size", {30'h0, m_last.size}, 32'(i % 3));
      check("store data", m_last.data & msk, 32'h11223344 & msk);
    end
    check("bad stores", 32'(bad_cnt), 32'h0);
    $display("test stores done");
    foreach (r_ins[k]) begin
      wr(A_PC, 32'h100);
      ex(r_ins[k], 32'h2000, 32'h5, r_in[k]);
      rdc(A_PC, 32'h104, "pc in slot");
      rdc(A_MSTATE, r_in[k], "flags in slot");
      wr(A_INSTR, 32'h88000000);
      rdc(A_RESULT, 32'h2005, "slot result");
      rdc(A_PC, 32'h1ff0, "return target");
      rdc(A_MSTATE, r_out[k], "flags after slot");
    end
    $display("test returns done");
    foreach (c_rows[i]) begin
      d0 = dc_cnt;
      i0 = ic_cnt;
      ex(c_rows[i].ins, c_rows[i].a, c_rows[i].b, c_rows[i].res);
      @(posedge pclk);
      check("dcache writes", 32'(dc_cnt - d0), {31'h0, c_rows[i].ci});
      check("icache writes", 32'(ic_cnt - i0), {31'h0, c_rows[i].co});
      if (c_rows[i].ci || c_rows[i].co) begin
        check("cache addr", c_last.addr, c_rows[i].a);
        check("cache data", c_last.data, c_rows[i].b);
        check("cache flags", {30'h0, c_last.valid, c_last.lock},
              {30'h0, c_rows[i].a[1:0]});
      end
    end
    $display("test caches done");
    apb(1'b0, 8'h30, 32'h0, d, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    apb(1'b1, A_RESULT, 32'h5, d, e);
    check("read-only error", {31'h0, e}, 32'h1);
    rdc(A_RESULT, 32'h2005, "result kept");
    wr(A_INSTR, 32'h0);
    rdc(A_STATUS, 32'h8, "illegal flag");
    $display("test errors done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("outs in reset", {29'h0, mem_o.we, cache_o.dc_we, cache_o.ic_we},
          32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_PC, 32'h0, "pc after second reset");
    $display("test second reset done");
    complete_run();
  end
endmodule
`default_nettype wire

// [tb/cx_far_model.sv]
/*
 Far-side model: data memory store port and cache write ports.
 Assumes every write pulse lasts one clock and is taken at once.
*/
`default_nettype none
module cx_far_model
  import cx_pkg::*;
(
  input  wire logic      pclk,       // Clock
  input  wire cx_mem_t   mem_i,      // Store port
  input  wire cx_cache_t cache_i,    // Cache write port
  output var  cx_mem_t   mem_last,   // Last store taken
  output var  cx_cache_t cache_last, // Last cache write taken
  output var  int        mem_cnt,    // Stores taken
  output var  int        dc_cnt,     // Data cache writes taken
  output var  int        ic_cnt,     // Instruction cache writes taken
  output var  int        bad_cnt     // Malformed stores seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mem_cnt = 0;
    dc_cnt  = 0;
    ic_cnt  = 0;
    bad_cnt = 0;
  end
  always @(posedge pclk) begin
    if (mem_i.we === 1'b1) begin
      mem_last <= mem_i;
      mem_cnt  <= mem_cnt + 1;
      // Memory takes unaligned or unknown-size stores but counts them as malformed
      if (mem_i.size == 2'h3 || (mem_i.size == SZ_HALF && mem_i.addr[0]) ||
          (mem_i.size == SZ_WORD && mem_i.addr[1:0] != 2'h0)) begin
        bad_cnt <= bad_cnt + 1;
      end
    end
    if (cache_i.dc_we === 1'b1 || cache_i.ic_we === 1'b1) begin
      cache_last <= cache_i;
    end
    if (cache_i.dc_we === 1'b1) begin
      dc_cnt <= dc_cnt + 1;
    end
    if (cache_i.ic_we === 1'b1) begin
      ic_cnt <= ic_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [verilog/cx_exec_core.sv]
/*
 Execution core for a subset of a 32-bit instruction set, APB slave.
 Assumes operands are loaded over APB before an instruction word is
 written; the memory and cache write ports accept every pulse.
*/
// What this block does
// - Reverse subtract literal: sext(imm) + ~a + 1
// - Carry-use bit adds carry instead of one
// - Keep-carry bit holds carry, else carry-out
// - Subtract carry means no borrow occurred
// - Opcode, destination, source, literal field layout
// - Returns load pc with a plus sext(imm)
// - Break return clears break flag after slot
// - Interrupt return sets enable after slot
// - Subroutine return runs delay slot first
// - Byte store writes low byte at sum
// - Halfword store clears address bit zero
// - Word store clears two address bits
// - Halfword widen copies bit 15 upward
// - Byte widen copies bit 7 upward
// - Arithmetic shift keeps sign, lsb to carry
// - Carry shift puts old carry in msb
// - Logical shift inserts zero, lsb to carry
// - Data cache write: tag, data, valid, lock
// - Data cache write only when cache off
// - Instruction cache write only when cache off
// - Register xor of a and b
// - Literal xor zero-extends the literal
`default_nettype none
module cx_exec_core
  import cx_pkg::*;
(
  input  wire logic        pclk,    // Clock
  input  wire logic        presetn, // Async reset, low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output var  logic [31:0] prdata,  // APB read data
  output var  logic        pready,  // APB ready
  output var  logic        pslverr, // APB error
  output var  cx_mem_t     mem_o,   // Data memory write
  output var  cx_cache_t   cache_o  // Cache write
);
  cx_state_t   r;
  cx_state_t   n;
  logic        setup;
  logic        wr_ok;
  logic        ex;
  logic        is_rs;
  logic [5:0]  op_w;
  logic [15:0] fn_w;
  logic [31:0] simm_w;

  assign setup  = psel && !penable && !r.pready;
  assign wr_ok  = psel && penable && r.pready && pwrite && !r.pslverr;
  assign ex     = wr_ok && paddr == A_INSTR;
  assign op_w   = pwdata[31:26];
  assign fn_w   = pwdata[15:0];
  assign simm_w = {{16{pwdata[15]}}, pwdata[15:0]};
  assign is_rs  = pwdata[31:29] == RS_HI && pwdata[26];
  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign mem_o   = r.mem;
  assign cache_o = r.cache;

  always_comb begin
    logic [32:0] sum;
    logic [31:0] adr;
    logic [31:0] rd_v;
    logic        cin;
    logic        hit;
    logic        ro;
    sum  = 33'h0;
    adr  = 32'h0;
    rd_v = 32'h0;
    cin  = 1'b0;
    hit  = 1'b1;
    ro   = 1'b0;
    n    = r;
    n.mem.we      = 1'b0;
    n.cache.dc_we = 1'b0;
    n.cache.ic_we = 1'b0;
    n.pready      = 1'b0;
    n.pslverr     = 1'b0;
    case (paddr)
      A_INSTR:  rd_v = r.instr;
      A_SRC_A:  rd_v = r.src_a;
      A_SRC_B:  rd_v = r.src_b;
      A_DATA:   rd_v = r.data;
      A_MSTATE: rd_v = {27'h0, r.mstate};
      A_PC:     rd_v = r.pc;
      A_RESULT: begin
        rd_v = r.result;
        ro   = 1'b1;
      end
      A_STATUS: begin
        rd_v = {19'h0, r.rd_idx, 4'h0, r.illegal, r.ret,
                r.ret != RET_NONE};
        ro   = 1'b1;
      end
      A_ST_ADR: begin
        rd_v = r.mem.addr;
        ro   = 1'b1;
      end
      A_ST_DAT: begin
        rd_v = r.mem.data;
        ro   = 1'b1;
      end
      default:  hit = 1'b0;
    endcase
    if (setup) begin
      n.pready  = 1'b1;
      n.prdata  = pwrite ? 32'h0 : rd_v;
      n.pslverr = !hit || (pwrite && ro);
    end
    if (wr_ok) begin
      case (paddr)
        A_SRC_A:  n.src_a  = pwdata;
        A_SRC_B:  n.src_b  = pwdata;
        A_DATA:   n.data   = pwdata;
        A_MSTATE: n.mstate = pwdata[MS_W-1:0];
        A_PC:     n.pc     = pwdata;
        default:  ;
      endcase
    end
    if (ex) begin
      n.instr   = pwdata;
      n.rd_idx  = pwdata[25:21];
      n.illegal = 1'b0;
      n.pc      = r.pc + 32'h4;
      // Pending return resolves after its delay slot
      case (r.ret)
        RET_BRK: begin
          n.pc = r.tgt;
          n.mstate[F_BRK] = 1'b0;
        end
        RET_INT: begin
          n.pc = r.tgt;
          n.mstate[F_IEN] = 1'b1;
        end
        RET_SUB: n.pc = r.tgt;
        default: ;
      endcase
      n.ret = RET_NONE;
      cin = pwdata[27] ? r.mstate[F_CARRY] : 1'b1;
      sum = {1'b0, simm_w} + {1'b0, ~r.src_a} + {32'h0, cin};
      adr = r.src_a + (pwdata[29] ? simm_w : r.src_b);
      if (is_rs) begin
        n.result = sum[31:0];
        if (!pwdata[28]) begin
          n.mstate[F_CARRY] = sum[32];
        end
      end else begin
        case (op_w)
          OP_RET: begin
            n.tgt = r.src_a + simm_w;
            case (pwdata[25:21])
              SUB_RTS: n.ret = RET_SUB;
              SUB_RTI: n.ret = RET_INT;
              SUB_RTB: n.ret = RET_BRK;
              default: n.illegal = 1'b1;
            endcase
          end
          OP_ST_BYTE, OP_ST_BYTEI: begin
            n.mem.we   = 1'b1;
            n.mem.addr = adr;
            n.mem.data = {24'h0, r.data[7:0]};
            n.mem.size = SZ_BYTE;
          end
          OP_ST_HALF, OP_ST_HALFI: begin
            n.mem.we   = 1'b1;
            n.mem.addr = {adr[31:1], 1'b0};
            n.mem.data = {16'h0, r.data[15:0]};
            n.mem.size = SZ_HALF;
          end
          OP_ST_WORD, OP_ST_WORDI: begin
            n.mem.we   = 1'b1;
            n.mem.addr = {adr[31:2], 2'b00};
            n.mem.data = r.data;
            n.mem.size = SZ_WORD;
          end
          OP_XOR:   n.result = r.src_a ^ r.src_b;
          OP_XOR_I: n.result = r.src_a ^ {16'h0, fn_w};
          OP_MISC: begin
            case (fn_w)
              FN_SRA: begin
                n.result = {r.src_a[31], r.src_a[31:1]};
                n.mstate[F_CARRY] = r.src_a[0];
              end
              FN_SRC: begin
                n.result = {r.mstate[F_CARRY], r.src_a[31:1]};
                n.mstate[F_CARRY] = r.src_a[0];
              end
              FN_SRL: begin
                n.result = {1'b0, r.src_a[31:1]};
                n.mstate[F_CARRY] = r.src_a[0];
              end
              FN_SX8: begin
                n.result = {{24{r.src_a[7]}}, r.src_a[7:0]};
              end
              FN_SX16: begin
                n.result = {{16{r.src_a[15]}}, r.src_a[15:0]};
              end
              FN_WDC, FN_WIC: begin
                // Direct cache fill, only while that cache is off
                n.cache.addr  = r.src_a;
                n.cache.data  = r.src_b;
                n.cache.valid = r.src_a[1];
                n.cache.lock  = r.src_a[0];
                n.cache.dc_we = fn_w == FN_WDC &&
                                !r.mstate[F_DCE];
                n.cache.ic_we = fn_w == FN_WIC &&
                                !r.mstate[F_ICE];
              end
              default: n.illegal = 1'b1;
            endcase
          end
          default: n.illegal = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ret(logic [4:0] sub);
    ex && op_w == OP_RET && pwdata[25:21] == sub && r.ret == RET_NONE;
  endsequence
  sequence s_slot(cx_ret_t k);
    ex && r.ret == k;
  endsequence

  property p_rs_plain;
    ex && is_rs && !pwdata[27] && !pwdata[28] |=>
      r.result == $past(simm_w) - $past(r.src_a) &&
      r.mstate[F_CARRY] == ($past(simm_w) >= $past(r.src_a));
  endproperty
  a_rs_plain: assert property (p_rs_plain)
    else $error("rsub");
  property p_rs_cin;
    ex && is_rs && pwdata[27] |=> r.result == $past(simm_w) -
      $past(r.src_a) - {31'h0, !$past(r.mstate[F_CARRY])};
  endproperty
  a_rs_cin: assert property (p_rs_cin)
    else $error("rsub carry");
  property p_rs_keep;
    ex && is_rs && pwdata[28] |=> $stable(r.mstate[F_CARRY]);
  endproperty
  a_rs_keep: assert property (p_rs_keep)
    else $error("keep");
  property p_fields;
    ex |=> r.rd_idx == $past(pwdata[25:21]) && r.instr == $past(pwdata);
  endproperty
  a_fields: assert property (p_fields)
    else $error("fields");
  property p_tgt;
    ex && op_w == OP_RET |=> r.tgt == $past(r.src_a) + $past(simm_w);
  endproperty
  a_tgt: assert property (p_tgt)
    else $error("target");
  // Break flag stays set until the slot instruction has run
  property p_brk;
    s_ret(SUB_RTB) |=> r.ret == RET_BRK && $stable(r.mstate[F_BRK]);
  endproperty
  a_brk: assert property (p_brk)
    else $error("break return");
  property p_brk_slot;
    s_slot(RET_BRK) |=> !r.mstate[F_BRK] && r.pc == $past(r.tgt);
  endproperty
  a_brk_slot: assert property (p_brk_slot)
    else $error("break slot");
  property p_int;
    s_slot(RET_INT) |=> r.mstate[F_IEN] && r.pc == $past(r.tgt) &&
      r.ret == RET_NONE;
  endproperty
  a_int: assert property (p_int)
    else $error("int return");
  property p_int_ret;
    s_ret(SUB_RTI) |=> r.ret == RET_INT && $stable(r.mstate[F_IEN]);
  endproperty
  a_int_ret: assert property (p_int_ret)
    else $error("int slot flag");
  property p_sub;
    s_ret(SUB_RTS) |=> r.ret == RET_SUB && r.pc == $past(r.pc) + 32'h4;
  endproperty
  a_sub: assert property (p_sub)
    else $error("sub return");
  property p_sub_slot;
    s_slot(RET_SUB) |=> r.pc == $past(r.tgt);
  endproperty
  a_sub_slot: assert property (p_sub_slot)
    else $error("sub slot");
  property p_byte;
    ex && (op_w == OP_ST_BYTE) |=> mem_o.we &&
      mem_o.addr == $past(r.src_a) + $past(r.src_b) &&
      mem_o.data[7:0] == $past(r.data[7:0]) ##1 !mem_o.we;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte store");
  property p_byte_imm;
    ex && op_w == OP_ST_BYTEI |=> mem_o.we && mem_o.size == SZ_BYTE &&
      mem_o.addr == $past(r.src_a + simm_w);
  endproperty
  a_byte_imm: assert property (p_byte_imm)
    else $error("byte store literal");
  property p_half;
    ex && (op_w == OP_ST_HALFI) |=> mem_o.we && !mem_o.addr[0] &&
      mem_o.addr == ($past(r.src_a + simm_w) & 32'hfffffffe) &&
      mem_o.data[15:0] == $past(r.data[15:0]);
  endproperty
  a_half: assert property (p_half)
    else $error("half store");
  property p_word;
    ex && op_w == OP_ST_WORD |=> mem_o.we && mem_o.addr[1:0] == 2'b00 &&
      mem_o.data == $past(r.data) && mem_o.size == SZ_WORD;
  endproperty
  a_word: assert property (p_word)
    else $error("word store");
  property p_sx16;
    ex && op_w == OP_MISC && fn_w == FN_SX16 |=>
      r.result == 32'($signed($past(r.src_a[15:0])));
  endproperty
  a_sx16: assert property (p_sx16)
    else $error("half widen");
  property p_sx8;
    ex && op_w == OP_MISC && fn_w == FN_SX8 |=>
      r.result == 32'($signed($past(r.src_a[7:0])));
  endproperty
  a_sx8: assert property (p_sx8)
    else $error("byte widen");
  property p_sra;
    ex && op_w == OP_MISC && fn_w == FN_SRA |=> r.mstate[F_CARRY] ==
      $past(r.src_a[0]) && r.result == 32'($signed($past(r.src_a)) >>> 1);
  endproperty
  a_sra: assert property (p_sra)
    else $error("arith shift");
  property p_src;
    ex && op_w == OP_MISC && fn_w == FN_SRC |=> r.result[31] ==
      $past(r.mstate[F_CARRY]) && r.mstate[F_CARRY] == $past(r.src_a[0]);
  endproperty
  a_src: assert property (p_src)
    else $error("carry shift");
  property p_srl;
    ex && op_w == OP_MISC && fn_w == FN_SRL |=>
      r.result == $past(r.src_a) >> 1 && r.mstate[F_CARRY] ==
      $past(r.src_a[0]);
  endproperty
  a_srl: assert property (p_srl)
    else $error("logic shift");
  property p_wdc;
    ex && op_w == OP_MISC && fn_w == FN_WDC |=> cache_o.dc_we !=
      $past(r.mstate[F_DCE]) && cache_o.valid == $past(r.src_a[1]) &&
      cache_o.data == $past(r.src_b) && !cache_o.ic_we;
  endproperty
  a_wdc: assert property (p_wdc)
    else $error("dcache write");
  property p_wdc_tag;
    ex && op_w == OP_MISC && fn_w == FN_WDC |=>
      cache_o.addr == $past(r.src_a) && cache_o.lock == $past(r.src_a[0]);
  endproperty
  a_wdc_tag: assert property (p_wdc_tag)
    else $error("dcache tag");
  property p_wic;
    ex && op_w == OP_MISC && fn_w == FN_WIC |=> cache_o.ic_we !=
      $past(r.mstate[F_ICE]) && cache_o.addr == $past(r.src_a);
  endproperty
  a_wic: assert property (p_wic)
    else $error("icache write");
  property p_xor;
    ex && (op_w == OP_XOR || op_w == OP_XOR_I) |=> r.result[15:0] ==
      ($past(r.src_a[15:0]) ^ $past(pwdata[15:0]) ^
      ($past(op_w) == OP_XOR ? ($past(r.src_b[15:0]) ^
      $past(pwdata[15:0])) : 16'h0)) &&
      r.result[31:16] == ($past(r.src_a[31:16]) ^
      ($past(op_w) == OP_XOR ? $past(r.src_b[31:16]) : 16'h0));
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor");
endmodule
`default_nettype wire

// [verilog/cx_pkg.sv]
/*
 Constants, opcodes and carriers of the execution core.
 Assumes an APB master on the register side and one clock.
*/
`default_nettype none
package cx_pkg;
  // APB byte addresses
  localparam logic [7:0] A_INSTR  = 8'h00;
  localparam logic [7:0] A_SRC_A  = 8'h04;
  localparam logic [7:0] A_SRC_B  = 8'h08;
  localparam logic [7:0] A_DATA   = 8'h0c;
  localparam logic [7:0] A_MSTATE = 8'h10;
  localparam logic [7:0] A_PC     = 8'h14;
  localparam logic [7:0] A_RESULT = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [7:0] A_ST_ADR = 8'h20;
  localparam logic [7:0] A_ST_DAT = 8'h24;
  // Machine state bit positions
  localparam int F_CARRY = 0;
  localparam int F_BRK   = 1;
  localparam int F_IEN   = 2;
  localparam int F_DCE   = 3;
  localparam int F_ICE   = 4;
  localparam int MS_W    = 5;
  // Instruction fields
  localparam logic [2:0] RS_HI = 3'b001;
  localparam logic [5:0] OP_RET      = 6'h2d;
  localparam logic [5:0] OP_ST_BYTE  = 6'h34;
  localparam logic [5:0] OP_ST_HALF  = 6'h35;
  localparam logic [5:0] OP_ST_WORD  = 6'h36;
  localparam logic [5:0] OP_ST_BYTEI = 6'h3c;
  localparam logic [5:0] OP_ST_HALFI = 6'h3d;
  localparam logic [5:0] OP_ST_WORDI = 6'h3e;
  localparam logic [5:0] OP_XOR      = 6'h22;
  localparam logic [5:0] OP_XOR_I    = 6'h2a;
  localparam logic [5:0] OP_MISC     = 6'h24;
  localparam logic [4:0] SUB_RTS = 5'h10;
  localparam logic [4:0] SUB_RTI = 5'h11;
  localparam logic [4:0] SUB_RTB = 5'h12;
  localparam logic [15:0] FN_SRA  = 16'h0001;
  localparam logic [15:0] FN_SRC  = 16'h0021;
  localparam logic [15:0] FN_SRL  = 16'h0041;
  localparam logic [15:0] FN_SX8  = 16'h0060;
  localparam logic [15:0] FN_SX16 = 16'h0061;
  localparam logic [15:0] FN_WDC  = 16'h0064;
  localparam logic [15:0] FN_WIC  = 16'h0068;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  typedef enum logic [1:0] {RET_NONE, RET_BRK, RET_INT, RET_SUB} cx_ret_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  size;
    logic        we;
  } cx_mem_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        valid;
    logic        lock;
    logic        dc_we;
    logic        ic_we;
  } cx_cache_t;

  typedef struct packed {
    logic [31:0]     instr;
    logic [31:0]     src_a;
    logic [31:0]     src_b;
    logic [31:0]     data;
    logic [MS_W-1:0] mstate;
    logic [31:0]     pc;
    logic [31:0]     tgt;
    logic [31:0]     result;
    cx_ret_t         ret;
    logic            illegal;
    logic [4:0]      rd_idx;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    cx_mem_t         mem;
    cx_cache_t       cache;
  } cx_state_t;

  localparam cx_state_t ST_RST = '0;
endpackage
`default_nettype wire
